// File: hdl/frame_clocked_watchdog.sv
// Frame clocked watchdog: restart key register and active-low sanity output.
// Assumes pins arrive asynchronously to sys_clk_i (10 MHz) and the frame pulse is much slower.
//
// Summary of operation
// (RULE_01) Output held low while in reset.
// (RULE_02) After reset: output high, count from zero.
// (RULE_03) Host writes key xxx01010 each period.
// (RULE_04) Timely restarts keep output continuously high.
// (RULE_05) Timeout after 512 frame pulses without restart.
// (RULE_06) Timeout: low one period, then toggle each period.
// (RULE_07) Count advances only on frame pulse falls.
// (RULE_08) Runs without chip select ever being asserted.
// (RULE_09) Wrong key writes change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defs.svh"
module frame_clocked_watchdog
  import watchdog_pkg::*;
#(
  parameter int PERIOD_FRAMES = `WDG_PERIOD_FRAMES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_n_i,
  input wire logic frame_pulse_n_i,
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_data_i,
  output logic sanity_out_n_o
);

  localparam int CW = $clog2(PERIOD_FRAMES);
  localparam logic [CW-1:0] COUNT_LAST = CW'(PERIOD_FRAMES - 1);
  localparam int SW = 20;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [SW-1:0] pins_async;
  logic [SW-1:0] pins_sync;
  logic por_n_sync;
  logic frame_n_sync;
  logic cs_n_sync;
  logic wr_n_sync;
  logic [7:0] addr_sync;
  logic [7:0] data_sync;

  assign pins_async = {power_on_reset_n_i, frame_pulse_n_i, chip_select_n_i,
                       write_strobe_n_i, bus_addr_i, bus_data_i};

  pin_synchronizer #(
    .WIDTH(SW),
    .RESET_VALUE({4'hF, 16'h0000})
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  assign por_n_sync = pins_sync[19];
  assign frame_n_sync = pins_sync[18];
  assign cs_n_sync = pins_sync[17];
  assign wr_n_sync = pins_sync[16];
  assign addr_sync = pins_sync[15:8];
  assign data_sync = pins_sync[7:0];

  // ----------------------------------------
  // Edge detection and write capture
  // ----------------------------------------
  logic frame_n_prev_reg;
  logic wr_n_prev_reg;
  logic cs_active_reg;
  logic [7:0] addr_cap_reg;
  logic [7:0] data_cap_reg;
  logic held_in_reset;
  logic frame_fall;
  logic write_done;
  logic addr_hit;
  logic key_match;
  logic key_hit;

  // Pin reset counts the same as the synchronous reset
  assign held_in_reset = rst_i || !por_n_sync;
  assign frame_fall = frame_n_prev_reg && !frame_n_sync; // RULE_07
  // Write completes on the trailing edge of the strobe; data captured while low
  assign write_done = wr_n_sync && !wr_n_prev_reg && cs_active_reg;
  assign addr_hit = (addr_cap_reg == `WDG_RESTART_OFFSET);
  assign key_match = ((data_cap_reg & `WDG_KEY_MASK) == `WDG_KEY_VALUE);
  assign key_hit = write_done && addr_hit && key_match; // RULE_09

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      frame_n_prev_reg <= 1'b1;
      wr_n_prev_reg <= 1'b1;
      cs_active_reg <= 1'b0;
      addr_cap_reg <= 8'h00;
      data_cap_reg <= 8'h00;
    end else begin
      frame_n_prev_reg <= frame_n_sync;
      wr_n_prev_reg <= wr_n_sync;
      if (!wr_n_sync) begin
        cs_active_reg <= !cs_n_sync;
        addr_cap_reg <= addr_sync;
        data_cap_reg <= data_sync;
      end
    end
  end

  // ----------------------------------------
  // Period counter and output
  // ----------------------------------------
  wdg_state_t state_reg;
  wdg_state_t state_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic out_reg;
  logic out_next;
  logic period_end;

  assign period_end = frame_fall && (count_reg == COUNT_LAST); // RULE_05

  // Key write beats a coincident frame edge so a late restart is not lost
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    out_next = out_reg;
    if (key_hit) begin
      state_next = ST_RUN; // RULE_03
      count_next = '0;
      out_next = 1'b1;
    end else begin
      case (state_reg)
        ST_RUN: begin
          out_next = 1'b1; // RULE_04
          if (period_end) begin
            state_next = ST_TIMEOUT; // RULE_05
            count_next = '0;
            out_next = 1'b0; // RULE_06
          end else if (frame_fall) begin
            count_next = count_reg + 1'b1; // RULE_08
          end
        end
        ST_TIMEOUT: begin
          if (period_end) begin
            count_next = '0;
            out_next = !out_reg; // RULE_06
          end else if (frame_fall) begin
            count_next = count_reg + 1'b1;
          end
        end
        default: begin
          state_next = ST_RUN;
          count_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (held_in_reset) begin
      state_reg <= ST_RUN; // RULE_02
      count_reg <= '0;
      out_reg <= 1'b0; // RULE_01
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      out_reg <= out_next;
    end
  end

  assign sanity_out_n_o = out_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_reset_low: assert property ( // RULE_01
    @(posedge sys_clk_i) disable iff (rst_i)
    held_in_reset |=> !sanity_out_n_o)
    else $error("sanity output not low during reset");

  chk_release_high: assert property ( // RULE_02
    @(posedge sys_clk_i) disable iff (rst_i)
    $past(held_in_reset) && !held_in_reset |=> sanity_out_n_o && count_reg <= 1)
    else $error("no restart after reset release");

  chk_run_stays_high: assert property ( // RULE_04
    @(posedge sys_clk_i) disable iff (held_in_reset)
    state_reg == ST_RUN && $past(state_reg) == ST_RUN && !$past(held_in_reset) |-> sanity_out_n_o)
    else $error("output dropped while running");

  chk_timeout_fires: assert property ( // RULE_05
    @(posedge sys_clk_i) disable iff (held_in_reset)
    state_reg == ST_RUN && period_end && !key_hit |=> state_reg == ST_TIMEOUT && !sanity_out_n_o)
    else $error("timeout missed at period end");

  chk_no_early_timeout: assert property ( // RULE_05
    @(posedge sys_clk_i) disable iff (held_in_reset)
    state_reg == ST_RUN && !period_end |=> state_reg == ST_RUN)
    else $error("timeout before period end");

  chk_timeout_toggle: assert property ( // RULE_06
    @(posedge sys_clk_i) disable iff (held_in_reset)
    state_reg == ST_TIMEOUT && period_end && !key_hit |=> sanity_out_n_o != $past(sanity_out_n_o))
    else $error("no toggle at period end");

  chk_edge_only: assert property ( // RULE_07
    @(posedge sys_clk_i) disable iff (held_in_reset)
    !frame_fall && !key_hit ##1 !$past(held_in_reset) |-> $stable(count_reg))
    else $error("count moved without frame edge");

  chk_count_unselected: assert property ( // RULE_08
    @(posedge sys_clk_i) disable iff (held_in_reset)
    frame_fall && !period_end && !key_hit |=> count_reg == $past(count_reg) + 1'b1)
    else $error("count did not advance");

  chk_key_restart: assert property ( // RULE_03
    @(posedge sys_clk_i) disable iff (held_in_reset)
    key_hit |=> count_reg == '0 && sanity_out_n_o && state_reg == ST_RUN)
    else $error("key write did not restart");

  chk_bad_key_ignored: assert property ( // RULE_09
    @(posedge sys_clk_i) disable iff (held_in_reset)
    write_done && addr_hit && !key_match && !frame_fall |=> $stable(count_reg) && $stable(state_reg))
    else $error("bad key changed state");

endmodule
`default_nettype wire

// File: hdl/watchdog_defs.svh
// Constants of the frame clocked watchdog: offsets, key, counts.
// Assumes inclusion by bare name from design files only.
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

`define WDG_RESTART_OFFSET 8'h06
`define WDG_KEY_MASK 8'h1F
`define WDG_KEY_VALUE 8'h0A
`define WDG_PERIOD_FRAMES 512
`define WDG_SYNC_STAGES 2

`endif

// File: hdl/watchdog_pkg.sv
// Types shared by the frame clocked watchdog.
// Assumes compilation before any module that imports it.
package watchdog_pkg;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_TIMEOUT = 1'b1
  } wdg_state_t;

endpackage

// File: hdl/pin_synchronizer.sv
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes every bit is sampled independently; groups must be stable when read.
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------
  // Per-bit double register
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          meta_reg <= RESET_VALUE[g];
          stable_reg <= RESET_VALUE[g];
        end else begin
          meta_reg <= async_i[g];
          stable_reg <= meta_reg;
        end
      end
      assign sync_o[g] = stable_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// File: testbench/host_model.sv
// Host model: byte writes on the watchdog bus pins.
// Assumes the bench clock; pins change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sys_clk_i,
  output logic chip_select_n_o,
  output logic write_strobe_n_o,
  output logic [7:0] bus_addr_o,
  output logic [7:0] bus_data_o
);
  initial begin
    chip_select_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    bus_addr_o = 8'hFF;
    bus_data_o = 8'hFF;
  end
  // Released pins show inverted values, so stale data never looks valid
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    chip_select_n_o = 1'b0;
    write_strobe_n_o = 1'b0;
    bus_addr_o = addr;
    bus_data_o = data;
    repeat (4) @(negedge sys_clk_i);
    write_strobe_n_o = 1'b1;
    @(negedge sys_clk_i);
    chip_select_n_o = 1'b1;
    bus_addr_o = ~addr;
    bus_data_o = ~data;
    repeat (6) @(negedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the frame clocked watchdog.
// Assumes a short period parameter and a host model on the bus pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int P = 8;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_n = 1'b1;
  logic frame_n = 1'b1;
  logic cs_n, wr_n, sanity_n;
  logic [7:0] addr, data;
  int n_errors = 0;
  int comparisons = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  host_model host_u (.sys_clk_i(sys_clk_i), .chip_select_n_o(cs_n), .write_strobe_n_o(wr_n),
    .bus_addr_o(addr), .bus_data_o(data));
  frame_clocked_watchdog #(.PERIOD_FRAMES(P)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .power_on_reset_n_i(por_n), .frame_pulse_n_i(frame_n), .chip_select_n_i(cs_n),
    .write_strobe_n_i(wr_n), .bus_addr_i(addr), .bus_data_i(data), .sanity_out_n_o(sanity_n));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Low for 4 clocks: comfortably above the 2 clock sync minimum
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      frame_n = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      frame_n = 1'b1;
      repeat (6) @(negedge sys_clk_i);
    end
  endtask
  task automatic do_reset(input bit use_por);
    @(negedge sys_clk_i);
    if (use_por) begin
      por_n = 1'b0;
    end else begin
      rst_i = 1'b1;
    end
    repeat (4) @(negedge sys_clk_i);
    check("out_in_reset", 1'b0, sanity_n);
    por_n = 1'b1;
    rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    check("out_after_reset", 1'b1, sanity_n);
    $display("test reset done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_restart();
    repeat (3) begin
      frames(P - 1);
      check("out_kept_high", 1'b1, sanity_n);
      host_u.write_byte(8'h06, 8'h0A);
    end
    $display("test restart done");
  endtask
  task automatic test_bad_key();
    frames(3);
    host_u.write_byte(8'h06, 8'h0B);
    host_u.write_byte(8'h07, 8'h0A);
    frames(P - 4);
    check("out_before_expiry", 1'b1, sanity_n);
    frames(1);
    check("out_at_expiry", 1'b0, sanity_n);
    $display("test bad key done");
  endtask
  task automatic test_toggle();
    repeat (300) @(negedge sys_clk_i);
    check("out_frame_idle", 1'b0, sanity_n);
    frames(P - 1);
    check("out_low_period", 1'b0, sanity_n);
    frames(1);
    check("out_toggle_high", 1'b1, sanity_n);
    frames(P);
    check("out_toggle_low", 1'b0, sanity_n);
    host_u.write_byte(8'h06, 8'hEA);
    check("out_key_restart", 1'b1, sanity_n);
    frames(P - 1);
    check("out_after_restart", 1'b1, sanity_n);
    $display("test toggle done");
  endtask
  task automatic test_por();
    do_reset(1'b1);
    frames(P - 1);
    check("out_count_cleared", 1'b1, sanity_n);
    frames(1);
    check("out_expiry_after_por", 1'b0, sanity_n);
    $display("test power on reset done");
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    print_verdict();
  end
  initial begin
    do_reset(1'b0);
    test_restart();
    test_bad_key();
    test_toggle();
    test_por();
    print_verdict();
  end
endmodule
`default_nettype wire
